// *** hdl/buck_regulator_supervisor.sv ***
// supervisory logic for two step-down regulator channels and their sequencers
// Contract
// - kept enable on in normal and sleep.
// - dropped enable on in normal, off in sleep.
// - both enables on together in normal operation.
// - discharge on when channel off and not disabled.
// - undervoltage flag set below brownout threshold.
// - unmasked undervoltage flag requests power-down.
// - undervoltage blanked from enable until soft-start ends.
// - undervoltage blanked during ramp after target raise.
// - overvoltage flag set above threshold.
// - unmasked overvoltage requests power-down and interrupt.
// - falling ramp on: lowering target blanks overvoltage until ramp ends.
// - falling ramp off: lowering target keeps overvoltage live.
// - live status for undervoltage, overvoltage, current limit.
// - enable from sequencer or mode field, per configuration.
// - slave settings: participation, master, up and down slots.
// - two-bit mode field picks normal or low power.
// - optional low power in deep sleep.
// - mode field can force low power.
// - mode 00 off, 01 global request, 10 low, 11 normal.
// - master timer issues eight ordered slot events per edge.
`include "buck_supervisor_cfg.svh"

module buck_regulator_supervisor #(
    parameter int SLOT_PITCH_CYCLES = `BRS_SLOT_PITCH_CYC,
    parameter int CHANNELS = `BRS_CHANNELS
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    // processor state pins
    input wire logic application_processor_active_i,
    input wire logic application_processor_sleep_i,
    // global mode inputs
    input wire logic global_low_power_request_i,
    input wire logic deep_sleep_state_i,
    // master timer pitch selects
    input wire logic [2:0] kept_pitch_sel_i,
    input wire logic [2:0] dropped_pitch_sel_i,
    // per channel configuration, bit 0 is channel a, bit 1 channel b
    input wire logic [1:0] sequencer_source_i,
    input wire logic [1:0] master_select_i,
    input wire logic [2:0] channel_a_up_slot_i,
    input wire logic [2:0] channel_a_down_slot_i,
    input wire logic [2:0] channel_b_up_slot_i,
    input wire logic [2:0] channel_b_down_slot_i,
    input wire logic [1:0] channel_a_power_mode_field_i,
    input wire logic [1:0] channel_b_power_mode_field_i,
    input wire logic [1:0] sleep_low_power_enable_i,
    input wire logic [1:0] discharge_disable_i,
    input wire logic [1:0] undervoltage_mask_i,
    input wire logic [1:0] overvoltage_mask_i,
    input wire logic [1:0] falling_ramp_enable_i,
    input wire logic [6:0] channel_a_target_code_i,
    input wire logic [6:0] channel_b_target_code_i,
    input wire logic [1:0] undervoltage_flag_clear_i,
    input wire logic [1:0] overvoltage_flag_clear_i,
    // analog monitor pins
    input wire logic [1:0] undervoltage_compare_i,
    input wire logic [1:0] overvoltage_compare_i,
    input wire logic [1:0] current_limit_compare_i,
    input wire logic [1:0] ramp_busy_i,
    // sequencer enables
    output logic sleep_kept_sequencer_enable_o,
    output logic sleep_dropped_sequencer_enable_o,
    // per channel outputs
    output logic [1:0] channel_on_o,
    output logic [1:0] low_power_o,
    output logic [1:0] discharge_on_o,
    output logic [1:0] undervoltage_flag_o,
    output logic [1:0] overvoltage_flag_o,
    output logic [1:0] undervoltage_status_o,
    output logic [1:0] overvoltage_status_o,
    output logic [1:0] current_limit_status_o,
    // fault outputs
    output logic power_down_request_o,
    output logic interrupt_request_out_n_o
);

    // refuse channel counts the port widths cannot carry
    initial begin
        if (CHANNELS != `BRS_CHANNELS) begin
            $error("buck_regulator_supervisor: CHANNELS must equal the port width");
        end
    end

    logic [`BRS_SYNC_W-1:0] sync1_reg;
    logic [`BRS_SYNC_W-1:0] sync2_reg;
    logic proc_active_s;
    logic proc_sleep_s;
    logic [1:0] uv_s;
    logic [1:0] ov_s;
    logic [1:0] ilim_s;
    logic [1:0] busy_s;
    logic kept_en_reg;
    logic dropped_en_reg;
    logic pd_request_reg;
    logic irq_n_reg;
    logic [1:0] pd_bits;
    logic [1:0] irq_bits;
    logic [1:0] slot_event;
    logic [1:0] slot_up;
    logic [2:0] slot_index [2];
    logic [2:0] up_slot [2];
    logic [2:0] down_slot [2];
    logic [1:0] power_mode [2];
    logic [6:0] target_code [2];

    // per channel field arrays
    assign up_slot[0] = channel_a_up_slot_i;
    assign up_slot[1] = channel_b_up_slot_i;
    assign down_slot[0] = channel_a_down_slot_i;
    assign down_slot[1] = channel_b_down_slot_i;
    assign power_mode[0] = channel_a_power_mode_field_i;
    assign power_mode[1] = channel_b_power_mode_field_i;
    assign target_code[0] = channel_a_target_code_i;
    assign target_code[1] = channel_b_target_code_i;

    // two-flop synchroniser for every pin input
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (clk_en_i) begin
            sync1_reg <= {application_processor_active_i, application_processor_sleep_i,
                          undervoltage_compare_i, overvoltage_compare_i,
                          current_limit_compare_i, ramp_busy_i};
            sync2_reg <= sync1_reg;
        end
    end

    // unpack the synchronised bank
    assign proc_active_s = sync2_reg[9];
    assign proc_sleep_s = sync2_reg[8];
    assign uv_s = sync2_reg[7:6];
    assign ov_s = sync2_reg[5:4];
    assign ilim_s = sync2_reg[3:2];
    assign busy_s = sync2_reg[1:0];

    // sequencer enables from the processor state
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            kept_en_reg <= 1'b0;
            dropped_en_reg <= 1'b0;
        end else if (clk_en_i) begin
            kept_en_reg <= proc_active_s | proc_sleep_s;
            dropped_en_reg <= proc_active_s & ~proc_sleep_s;
        end
    end

    assign sleep_kept_sequencer_enable_o = kept_en_reg;
    assign sleep_dropped_sequencer_enable_o = dropped_en_reg;

    // master timer for the sleep-kept sequencer
    seq_master_timer #(
        .PITCH_CYCLES(SLOT_PITCH_CYCLES),
        .CNT_W(`BRS_PITCH_CNT_W)
    ) u_kept_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .enable_i(kept_en_reg),
        .pitch_sel_i(kept_pitch_sel_i),
        .slot_event_o(slot_event[0]),
        .slot_index_o(slot_index[0]),
        .slot_up_o(slot_up[0])
    );

    // master timer for the sleep-dropped sequencer
    seq_master_timer #(
        .PITCH_CYCLES(SLOT_PITCH_CYCLES),
        .CNT_W(`BRS_PITCH_CNT_W)
    ) u_dropped_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .enable_i(dropped_en_reg),
        .pitch_sel_i(dropped_pitch_sel_i),
        .slot_event_o(slot_event[1]),
        .slot_index_o(slot_index[1]),
        .slot_up_o(slot_up[1])
    );

    // one identical supervisor per channel
    for (genvar g = 0; g < `BRS_CHANNELS; g++) begin : g_chan
        logic seq_on_reg;
        logic on_reg;
        logic on_next;
        logic lp_reg;
        logic dis_reg;
        logic [6:0] code_prev_reg;
        logic raise;
        logic lower;
        logic uv_blank_reg;
        logic ov_blank_reg;
        logic [2:0] uv_guard_reg;
        logic [2:0] ov_guard_reg;
        logic uv_flag_reg;
        logic ov_flag_reg;
        logic uv_live_reg;
        logic ov_live_reg;
        logic ilim_live_reg;
        logic m;
        logic ev;

        // channel's timer event
        assign m = master_select_i[g];
        assign ev = slot_event[m];

        // sequencer slave state follows its assigned slots
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                seq_on_reg <= 1'b0;
            end else if (clk_en_i) begin
                if (ev && slot_up[m] && slot_index[m] == up_slot[g]) begin
                    seq_on_reg <= 1'b1;
                end else if (ev && !slot_up[m] && slot_index[m] == down_slot[g]) begin
                    seq_on_reg <= 1'b0;
                end
            end
        end

        // enable source select and mode decode
        assign on_next = (power_mode[g] != `BRS_MODE_OFF) &&
                         (!sequencer_source_i[g] || seq_on_reg);

        // on, low-power and discharge state
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                on_reg <= 1'b0;
                lp_reg <= 1'b0;
                dis_reg <= 1'b0;
            end else if (clk_en_i) begin
                on_reg <= on_next;
                lp_reg <= on_next && ((power_mode[g] == `BRS_MODE_LOW) ||
                          (power_mode[g] == `BRS_MODE_GLOBAL &&
                           (global_low_power_request_i ||
                            (sleep_low_power_enable_i[g] && deep_sleep_state_i))));
                dis_reg <= !discharge_disable_i[g] && !on_next;
            end
        end

        // target history
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                code_prev_reg <= 7'h00;
            end else if (clk_en_i) begin
                code_prev_reg <= target_code[g];
            end
        end

        assign raise = on_reg && (target_code[g] > code_prev_reg);
        assign lower = on_reg && (target_code[g] < code_prev_reg) && falling_ramp_enable_i[g];

        // undervoltage blanking: soft-start and upward ramp
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                uv_blank_reg <= 1'b0;
                uv_guard_reg <= 3'h0;
            end else if (clk_en_i) begin
                if ((on_next && !on_reg) || raise) begin
                    uv_blank_reg <= 1'b1;
                    uv_guard_reg <= `BRS_RAMP_GUARD;
                end else if (uv_guard_reg != 3'h0) begin
                    uv_guard_reg <= uv_guard_reg - 3'h1;
                end else if (!busy_s[g]) begin
                    uv_blank_reg <= 1'b0;
                end
            end
        end

        // overvoltage blanking for falling ramp
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                ov_blank_reg <= 1'b0;
                ov_guard_reg <= 3'h0;
            end else if (clk_en_i) begin
                if (lower) begin
                    ov_blank_reg <= 1'b1;
                    ov_guard_reg <= `BRS_RAMP_GUARD;
                end else if (ov_guard_reg != 3'h0) begin
                    ov_guard_reg <= ov_guard_reg - 3'h1;
                end else if (!busy_s[g] || !on_reg) begin
                    ov_blank_reg <= 1'b0;
                end
            end
        end

        // sticky flags, set wins over clear
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                uv_flag_reg <= 1'b0;
                ov_flag_reg <= 1'b0;
            end else if (clk_en_i) begin
                if (on_reg && uv_s[g] && !uv_blank_reg) begin
                    uv_flag_reg <= 1'b1;
                end else if (undervoltage_flag_clear_i[g]) begin
                    uv_flag_reg <= 1'b0;
                end
                if (on_reg && ov_s[g] && !ov_blank_reg) begin
                    ov_flag_reg <= 1'b1;
                end else if (overvoltage_flag_clear_i[g]) begin
                    ov_flag_reg <= 1'b0;
                end
            end
        end

        // live condition status, separate from the flags
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                uv_live_reg <= 1'b0;
                ov_live_reg <= 1'b0;
                ilim_live_reg <= 1'b0;
            end else if (clk_en_i) begin
                uv_live_reg <= uv_s[g];
                ov_live_reg <= ov_s[g];
                ilim_live_reg <= ilim_s[g];
            end
        end

        // unmasked fault contributions
        assign pd_bits[g] = (uv_flag_reg && !undervoltage_mask_i[g]) ||
                            (ov_flag_reg && !overvoltage_mask_i[g]);
        assign irq_bits[g] = ov_flag_reg && !overvoltage_mask_i[g];

        // channel outputs straight from their flops
        assign channel_on_o[g] = on_reg;
        assign low_power_o[g] = lp_reg;
        assign discharge_on_o[g] = dis_reg;
        assign undervoltage_flag_o[g] = uv_flag_reg;
        assign overvoltage_flag_o[g] = ov_flag_reg;
        assign undervoltage_status_o[g] = uv_live_reg;
        assign overvoltage_status_o[g] = ov_live_reg;
        assign current_limit_status_o[g] = ilim_live_reg;
    end

    // combined power-down request and interrupt line
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pd_request_reg <= 1'b0;
            irq_n_reg <= 1'b1;
        end else if (clk_en_i) begin
            pd_request_reg <= |pd_bits;
            irq_n_reg <= ~(|irq_bits);
        end
    end

    assign power_down_request_o = pd_request_reg;
    assign interrupt_request_out_n_o = irq_n_reg;

endmodule

// *** hdl/buck_supervisor_cfg.svh ***
// constants for the buck regulator supervisor: timing, codes, field widths
`ifndef BUCK_SUPERVISOR_CFG_SVH
`define BUCK_SUPERVISOR_CFG_SVH

// system clock rate
`define BRS_CLK_HZ 50000000
// base time between sequencer slots, in ns
`define BRS_SLOT_PITCH_NS 31000
// slot pitch in cycles, rounded up
`define BRS_SLOT_PITCH_CYC ((`BRS_SLOT_PITCH_NS * (`BRS_CLK_HZ / 1000000) + 999) / 1000)
// slot counter width
`define BRS_PITCH_CNT_W 18
// number of slots per sequence and last slot index
`define BRS_SLOT_COUNT 8
`define BRS_SLOT_LAST 3'h7
// number of regulator channels
`define BRS_CHANNELS 2
// power mode field codes
`define BRS_MODE_OFF 2'h0
`define BRS_MODE_GLOBAL 2'h1
`define BRS_MODE_LOW 2'h2
`define BRS_MODE_NORMAL 2'h3
// guard cycles before the ramp flag is trusted
`define BRS_RAMP_GUARD 3'h7
// synchroniser bank width
`define BRS_SYNC_W 10

`endif

// *** hdl/buck_supervisor_pkg.sv ***
// types shared by the buck regulator supervisor files
package buck_supervisor_pkg;

    // master sequencing timer states, one-hot
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_UP = 3'b010,
        SEQ_DOWN = 3'b100
    } seq_state_e;

    typedef logic [6:0] target_code_t;
    typedef logic [1:0] power_mode_t;
    typedef logic [2:0] slot_index_t;

endpackage

// *** hdl/seq_master_timer.sv ***
// master sequencing timer: eight ordered slot events per enable edge
`include "buck_supervisor_cfg.svh"

module seq_master_timer #(
    parameter int PITCH_CYCLES = `BRS_SLOT_PITCH_CYC,
    parameter int CNT_W = `BRS_PITCH_CNT_W
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic enable_i,
    input wire logic [2:0] pitch_sel_i,
    output logic slot_event_o,
    output buck_supervisor_pkg::slot_index_t slot_index_o,
    output logic slot_up_o
);

    // refuse pitches the counter cannot hold
    initial begin
        if (PITCH_CYCLES < 1 || (PITCH_CYCLES * 128) >= (2 ** CNT_W)) begin
            $error("seq_master_timer: PITCH_CYCLES does not fit the counter");
        end
    end

    buck_supervisor_pkg::seq_state_e state_reg;
    logic enable_seen_reg;
    logic [CNT_W-1:0] cnt_reg;
    buck_supervisor_pkg::slot_index_t slot_reg;
    logic [CNT_W-1:0] limit;

    // pitch scales by binary steps
    assign limit = (CNT_W'(PITCH_CYCLES) << pitch_sel_i) - CNT_W'(1);

    // sequence walk; a new edge arriving mid-walk waits for the idle state
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= buck_supervisor_pkg::SEQ_IDLE;
            enable_seen_reg <= 1'b0;
            cnt_reg <= '0;
            slot_reg <= 3'h0;
            slot_event_o <= 1'b0;
            slot_index_o <= 3'h0;
            slot_up_o <= 1'b0;
        end else if (clk_en_i) begin
            slot_event_o <= 1'b0;
            unique case (state_reg)
                buck_supervisor_pkg::SEQ_IDLE: begin
                    if (enable_i != enable_seen_reg) begin
                        enable_seen_reg <= enable_i;
                        cnt_reg <= '0;
                        slot_reg <= 3'h0;
                        state_reg <= enable_i ? buck_supervisor_pkg::SEQ_UP :
                                                buck_supervisor_pkg::SEQ_DOWN;
                    end
                end
                buck_supervisor_pkg::SEQ_UP, buck_supervisor_pkg::SEQ_DOWN: begin
                    if (cnt_reg == limit) begin
                        cnt_reg <= '0;
                        slot_event_o <= 1'b1;
                        slot_index_o <= slot_reg;
                        slot_up_o <= (state_reg == buck_supervisor_pkg::SEQ_UP);
                        slot_reg <= slot_reg + 3'h1;
                        if (slot_reg == `BRS_SLOT_LAST) begin
                            state_reg <= buck_supervisor_pkg::SEQ_IDLE;
                        end
                    end else begin
                        cnt_reg <= cnt_reg + CNT_W'(1);
                    end
                end
            endcase
        end
    end

endmodule

// *** test/buck_converter_model.sv ***
// converter model: ramp flag and comparator pins seen by the supervisor
module buck_converter_model (
    input wire logic clk_i,
    input wire logic [1:0] on_i,
    input wire logic [6:0] code_a_i,
    input wire logic [6:0] code_b_i,
    input wire logic slow_i,
    input wire logic [1:0] uv_fault_i,
    input wire logic [1:0] ov_fault_i,
    input wire logic [1:0] cl_fault_i,
    output logic [1:0] uv_o,
    output logic [1:0] ov_o,
    output logic [1:0] cl_o,
    output logic [1:0] busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt [2] = '{8'h0, 8'h0};
    logic [6:0] code_q [2] = '{7'h0, 7'h0};
    logic [1:0] down = 2'h0;
    logic [1:0] on_q = 2'h0;
    logic [6:0] code [2];
    assign code[0] = code_a_i;
    assign code[1] = code_b_i;
    // ramp starts on enable or target change
    always @(posedge clk_i) begin
        for (int c = 0; c < 2; c++) begin
            if (on_i[c] && (!on_q[c] || code[c] != code_q[c])) begin
                cnt[c] <= slow_i ? 8'h28 : 8'h05;
                down[c] <= on_q[c] && code[c] < code_q[c];
            end else if (cnt[c] != 8'h0) begin
                cnt[c] <= cnt[c] - 8'h1;
            end
            on_q[c] <= on_i[c];
            code_q[c] <= code[c];
        end
    end
    // off output is low; ramp settles a cycle before the flag drops
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            busy_o[c] = cnt[c] != 8'h0;
            uv_o[c] = uv_fault_i[c] | !on_i[c] | (cnt[c] > 8'h1 && !down[c]);
            ov_o[c] = ov_fault_i[c] | (cnt[c] > 8'h1 && down[c]);
            cl_o[c] = cl_fault_i[c];
        end
    end
endmodule

// *** test/buck_supervisor_monitor.sv ***
// supervisor port checker
module buck_supervisor_monitor (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic application_processor_active_i,
    input wire logic application_processor_sleep_i,
    input wire logic global_low_power_request_i,
    input wire logic deep_sleep_state_i,
    input wire logic [1:0] sequencer_source_i,
    input wire logic [1:0] channel_a_power_mode_field_i,
    input wire logic [1:0] sleep_low_power_enable_i,
    input wire logic [1:0] discharge_disable_i,
    input wire logic [1:0] undervoltage_mask_i,
    input wire logic [1:0] overvoltage_mask_i,
    input wire logic [1:0] undervoltage_flag_clear_i,
    input wire logic sleep_kept_sequencer_enable_o,
    input wire logic sleep_dropped_sequencer_enable_o,
    input wire logic [1:0] channel_on_o,
    input wire logic [1:0] low_power_o,
    input wire logic [1:0] discharge_on_o,
    input wire logic [1:0] undervoltage_flag_o,
    input wire logic [1:0] overvoltage_flag_o,
    input wire logic [1:0] overvoltage_status_o,
    input wire logic power_down_request_o,
    input wire logic interrupt_request_out_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // processor pins reach the enables three edges later
    property p_kept;
        sleep_kept_sequencer_enable_o == ($past(application_processor_active_i, 3)
            | $past(application_processor_sleep_i, 3));
    endproperty
    a_kept: assert property (p_kept) else $error("kept enable wrong");
    property p_drop;
        sleep_dropped_sequencer_enable_o == ($past(application_processor_active_i, 3)
            & !$past(application_processor_sleep_i, 3));
    endproperty
    a_drop: assert property (p_drop) else $error("dropped enable wrong");
    property p_both;
        sleep_dropped_sequencer_enable_o |-> sleep_kept_sequencer_enable_o;
    endproperty
    a_both: assert property (p_both) else $error("enables not together");
    property p_disc;
        $past(rst_b_i) |-> discharge_on_o == (~$past(discharge_disable_i) & ~channel_on_o);
    endproperty
    a_disc: assert property (p_disc) else $error("discharge path wrong");
    property p_uv_hold;
        undervoltage_flag_o[0] && !undervoltage_flag_clear_i[0] |=> undervoltage_flag_o[0];
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("uv flag lost");
    property p_ov_set;
        $rose(overvoltage_flag_o[0]) |-> overvoltage_status_o[0];
    endproperty
    a_ov_set: assert property (p_ov_set) else $error("ov flag without cause");
    property p_pd;
        power_down_request_o == $past(|(undervoltage_flag_o & ~undervoltage_mask_i)
            | |(overvoltage_flag_o & ~overvoltage_mask_i));
    endproperty
    a_pd: assert property (p_pd) else $error("power-down request wrong");
    property p_irq;
        interrupt_request_out_n_o == !$past(|(overvoltage_flag_o & ~overvoltage_mask_i));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output wrong");
    property p_on;
        !$past(sequencer_source_i[0]) |-> channel_on_o[0]
            == ($past(channel_a_power_mode_field_i) != 2'h0);
    endproperty
    a_on: assert property (p_on) else $error("channel on wrong");
    property p_lp;
        !$past(sequencer_source_i[0]) |-> low_power_o[0]
            == ($past(channel_a_power_mode_field_i) == 2'h2
            || ($past(channel_a_power_mode_field_i) == 2'h1 && ($past(global_low_power_request_i)
            || ($past(deep_sleep_state_i) && $past(sleep_low_power_enable_i[0])))));
    endproperty
    a_lp: assert property (p_lp) else $error("low power wrong");
    c_pd: cover property ($rose(power_down_request_o));
    c_irq: cover property ($fell(interrupt_request_out_n_o));
    c_seq: cover property ($rose(channel_on_o[1]));
endmodule
bind buck_regulator_supervisor buck_supervisor_monitor u_mon (.*);

// *** test/test_buck_regulator_supervisor.sv ***
// supervisor testbench
`define chk(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module test_buck_regulator_supervisor;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b_i = 0, act = 0, slp = 0, glb = 0, dsl = 0, slow = 1;
    logic [2:0] psel = 3'h0, upb = 3'h3, dnb = 3'h5;
    logic [1:0] src = 2'h2, msel = 2'h2, mode_a = 2'h0, mode_b = 2'h3, slpen = 2'h0, dis = 2'h0;
    logic [1:0] uvm = 2'h0, ovm = 2'h0, fre = 2'h0, uvc = 2'h0, ovc = 2'h0;
    logic [1:0] fuv = 2'h0, fov = 2'h0, fcl = 2'h0;
    logic [6:0] tgt_a = 7'h20, tgt_b = 7'h20;
    logic kept, drop, pd, irq_n;
    logic [1:0] on, lp, disc, uvf, ovf, uvs, ovs, cls, uvp, ovp, clp, busy;
    int n_mismatch = 0, checked = 0;
    buck_regulator_supervisor #(.SLOT_PITCH_CYCLES(4)) dut (.clk_i(clk), .rst_b_i, .clk_en_i(1'b1),
        .application_processor_active_i(act), .application_processor_sleep_i(slp),
        .global_low_power_request_i(glb), .deep_sleep_state_i(dsl), .kept_pitch_sel_i(3'h0),
        .dropped_pitch_sel_i(psel), .sequencer_source_i(src), .master_select_i(msel),
        .channel_a_up_slot_i(3'h1), .channel_a_down_slot_i(3'h2), .channel_b_up_slot_i(upb),
        .channel_b_down_slot_i(dnb), .channel_a_power_mode_field_i(mode_a),
        .channel_b_power_mode_field_i(mode_b), .sleep_low_power_enable_i(slpen),
        .discharge_disable_i(dis), .undervoltage_mask_i(uvm), .overvoltage_mask_i(ovm),
        .falling_ramp_enable_i(fre), .channel_a_target_code_i(tgt_a),
        .channel_b_target_code_i(tgt_b), .undervoltage_flag_clear_i(uvc),
        .overvoltage_flag_clear_i(ovc), .undervoltage_compare_i(uvp), .overvoltage_compare_i(ovp),
        .current_limit_compare_i(clp), .ramp_busy_i(busy), .sleep_kept_sequencer_enable_o(kept),
        .sleep_dropped_sequencer_enable_o(drop), .channel_on_o(on), .low_power_o(lp),
        .discharge_on_o(disc), .undervoltage_flag_o(uvf), .overvoltage_flag_o(ovf),
        .undervoltage_status_o(uvs), .overvoltage_status_o(ovs), .current_limit_status_o(cls),
        .power_down_request_o(pd), .interrupt_request_out_n_o(irq_n));
    buck_converter_model conv (.clk_i(clk), .on_i(on), .code_a_i(tgt_a), .code_b_i(tgt_b),
        .slow_i(slow), .uv_fault_i(fuv), .ov_fault_i(fov), .cl_fault_i(fcl), .uv_o(uvp),
        .ov_o(ovp), .cl_o(clp), .busy_o(busy));
    // free running system clock
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // bounded wait for a channel state
    task automatic wait_on(input int b, input logic v);
        for (int n = 0; n < 100 && on[b] !== v; n++) @(negedge clk);
        `chk("channel on", v, on[b])
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog cuts a hung run short
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
    // main sequence
    initial begin
        tick(8);
        rst_b_i = 1;
        tick(2);
        `chk("discharge off chan", 1'b1, disc[0])
        act = 1;
        tick(10);
        `chk("kept", 1'b1, kept)
        `chk("dropped", 1'b1, drop)
        `chk("early slot", 1'b0, on[1])
        wait_on(1, 1'b1);
        `chk("seq discharge", 1'b0, disc[1])
        slp = 1;
        tick(5);
        `chk("kept in sleep", 1'b1, kept)
        `chk("dropped in sleep", 1'b0, drop)
        `chk("down slot wait", 1'b1, on[1])
        wait_on(1, 1'b0);
        `chk("seq discharge", 1'b1, disc[1])
        mode_a = 2'h3;
        tick(60);
        `chk("uv soft start", 1'b0, uvf[0])
        tgt_a = 7'h30;
        tick(60);
        `chk("uv raise", 1'b0, uvf[0])
        fuv[0] = 1;
        tick(5);
        `chk("uv status", 1'b1, uvs[0])
        `chk("uv flag", 1'b1, uvf[0])
        `chk("uv request", 1'b1, pd)
        fuv[0] = 0;
        uvm[0] = 1;
        tick(5);
        `chk("uv held", 1'b1, uvf[0])
        `chk("uv masked", 1'b0, pd)
        uvc[0] = 1;
        tick(1);
        uvc[0] = 0;
        `chk("uv cleared", 1'b0, uvf[0])
        fre[0] = 1;
        tgt_a = 7'h10;
        tick(60);
        `chk("ov ramp", 1'b0, ovf[0])
        fre[0] = 0;
        tgt_a = 7'h08;
        tick(20);
        `chk("ov flag", 1'b1, ovf[0])
        `chk("ov status", 1'b1, ovs[0])
        `chk("ov request", 1'b1, pd)
        `chk("ov irq", 1'b0, irq_n)
        ovm[0] = 1;
        ovc[0] = 1;
        tick(1);
        ovc[0] = 0;
        tgt_a = 7'h04;
        tick(20);
        `chk("ov masked flag", 1'b1, ovf[0])
        `chk("ov masked irq", 1'b1, irq_n)
        `chk("ov masked req", 1'b0, pd)
        fcl[1] = 1;
        tick(4);
        `chk("cl status", 1'b1, cls[1])
        for (int m = 0; m < 4; m++) begin
            for (int g = 0; g < 2; g++) begin
                mode_a = m[1:0];
                glb = g[0];
                tick(2);
                `chk("mode on", m != 0, on[0])
                `chk("mode lp", m == 2 || (m == 1 && g == 1), lp[0])
                `chk("mode discharge", m == 0, disc[0])
            end
        end
        mode_a = 2'h1;
        glb = 0;
        dsl = 1;
        slpen[0] = 1;
        tick(2);
        `chk("deep sleep lp", 1'b1, lp[0])
        mode_a = 2'h0;
        dis[0] = 1;
        tick(2);
        `chk("discharge disabled", 1'b0, disc[0])
        give_verdict();
    end
endmodule
